// *** rtl/sfo_exec.sv ***
// execute logic for status flag set/clear and transfer bit operations
// ------------------------------------------------------------
// Functional notes
// RULE1: bit load copies transfer flag into Rd bit
// RULE2: carry set or cleared, one cycle
// RULE3: negative set or cleared, one cycle
// RULE4: zero set or cleared, one cycle
// RULE5: global interrupt enable set or cleared
// RULE6: signed test flag set or cleared
// RULE7: overflow flag set or cleared, one cycle
// RULE8: bit store copies Rr bit into transfer
// RULE9: other state untouched; result visible next instruction
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module sfo_exec
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // decoded instruction, one per cycle
    input wire sfo_pkg::sfo_instr_t instr,
    // external status register load from other execute units
    input wire logic status_register_load,
    input wire logic [7:0] status_register_load_val,
    // external register file write from other execute units
    input wire sfo_pkg::sfo_rf_wr_t rf_ext_wr,
    // debug read of the register file
    input wire logic [4:0] dbg_addr,
    output logic [7:0] dbg_data,
    // status register view
    output logic [7:0] status_register,
    output logic irq_global_en,
    output logic done
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] status_register_q;
    logic [7:0] status_register_d;
    logic done_q;
    logic done_d;
    logic [7:0] rd_val;
    logic [4:0] rd_addr;
    sfo_pkg::sfo_rf_wr_t rf_wr;
    logic [7:0] dbg_q;
    logic [7:0] dbg_d;
    // decode strobes and the merged bit load word
    logic op_bit_load;
    logic op_bit_store;
    logic op_known;
    logic [7:0] load_data;

    // ------------------------------------------------------------
    // operation decode
    // ------------------------------------------------------------
    // one strobe per class of op; a refused code raises none of them
    always_comb
    begin
        op_bit_load = 1'b0;
        op_bit_store = 1'b0;
        op_known = 1'b0;
        case (instr.op)
            sfo_pkg::SFO_OP_BIT_LOAD:
            begin
                op_bit_load = instr.valid; // see RULE1
                op_known = 1'b1;
            end
            sfo_pkg::SFO_OP_BIT_STORE:
            begin
                op_bit_store = instr.valid; // see RULE8
                op_known = 1'b1;
            end
            sfo_pkg::SFO_OP_SET_C,
            sfo_pkg::SFO_OP_CLR_C,
            sfo_pkg::SFO_OP_SET_N,
            sfo_pkg::SFO_OP_CLR_N,
            sfo_pkg::SFO_OP_SET_Z,
            sfo_pkg::SFO_OP_CLR_Z,
            sfo_pkg::SFO_OP_IRQ_EN,
            sfo_pkg::SFO_OP_IRQ_DIS,
            sfo_pkg::SFO_OP_SET_S,
            sfo_pkg::SFO_OP_CLR_S,
            sfo_pkg::SFO_OP_SET_V,
            sfo_pkg::SFO_OP_CLR_V:
            begin
                op_known = 1'b1;
            end
            default:
            begin
                op_known = 1'b0; // the empty op and unknown codes are refused
            end
        endcase
    end

    // the register file read port is shared: a bit op owns it, else debug
    assign rd_addr = (op_bit_load || op_bit_store) ? instr.reg_sel : dbg_addr;

    sfo_regfile u_regfile
    (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .rd_addr(rd_addr),
        .rd_data(rd_val),
        .wr(rf_wr)
    );

    // ------------------------------------------------------------
    // status register next value
    // ------------------------------------------------------------
    // each flag set/clear op and bit store touches exactly one bit; others carry through unchanged
    always_comb
    begin
        status_register_d = status_register_q;
        if (status_register_load)
        begin
            status_register_d = status_register_load_val;
        end
        if (instr.valid)
        begin
            case (instr.op)
                sfo_pkg::SFO_OP_SET_C: status_register_d[sfo_pkg::SFO_BIT_C] = 1'b1; // see RULE2
                sfo_pkg::SFO_OP_CLR_C: status_register_d[sfo_pkg::SFO_BIT_C] = 1'b0; // see RULE2
                sfo_pkg::SFO_OP_SET_N: status_register_d[sfo_pkg::SFO_BIT_N] = 1'b1; // see RULE3
                sfo_pkg::SFO_OP_CLR_N: status_register_d[sfo_pkg::SFO_BIT_N] = 1'b0; // see RULE3
                sfo_pkg::SFO_OP_SET_Z: status_register_d[sfo_pkg::SFO_BIT_Z] = 1'b1; // see RULE4
                sfo_pkg::SFO_OP_CLR_Z: status_register_d[sfo_pkg::SFO_BIT_Z] = 1'b0; // see RULE4
                sfo_pkg::SFO_OP_IRQ_EN: status_register_d[sfo_pkg::SFO_BIT_I] = 1'b1; // see RULE5
                sfo_pkg::SFO_OP_IRQ_DIS: status_register_d[sfo_pkg::SFO_BIT_I] = 1'b0; // see RULE5
                sfo_pkg::SFO_OP_SET_S: status_register_d[sfo_pkg::SFO_BIT_S] = 1'b1; // see RULE6
                sfo_pkg::SFO_OP_CLR_S: status_register_d[sfo_pkg::SFO_BIT_S] = 1'b0; // see RULE6
                sfo_pkg::SFO_OP_SET_V: status_register_d[sfo_pkg::SFO_BIT_V] = 1'b1; // see RULE7
                sfo_pkg::SFO_OP_CLR_V: status_register_d[sfo_pkg::SFO_BIT_V] = 1'b0; // see RULE7
                sfo_pkg::SFO_OP_BIT_STORE:
                begin
                    status_register_d[sfo_pkg::SFO_BIT_T] = rd_val[instr.bit_sel]; // see RULE8
                end
                sfo_pkg::SFO_OP_BIT_LOAD: status_register_d = status_register_d; // flags untouched, see RULE1
                default: status_register_d = status_register_d; // refused code, flags untouched
            endcase
        end
    end

    // ------------------------------------------------------------
    // completion pulse
    // ------------------------------------------------------------
    // idle slots and refused codes give no pulse
    always_comb
    begin
        done_d = instr.valid && op_known;
    end

    // ------------------------------------------------------------
    // register file write path
    // ------------------------------------------------------------
    // own write wins over an external one in the same cycle; the decoder
    // never issues both, so this only defines the corner
    always_comb
    begin
        rf_wr = rf_ext_wr;
        if (op_bit_load)
        begin
            rf_wr.we = 1'b1;
            rf_wr.addr = instr.reg_sel;
            rf_wr.data = load_data; // see RULE1
        end
    end

    // ------------------------------------------------------------
    // bit load merge
    // ------------------------------------------------------------
    // every bit keeps its old value except the selected one, which takes T
    generate
        for (genvar g = 0; g < sfo_pkg::SFO_DATA_W; g++)
        begin : g_load_bit
            assign load_data[g] = (int'(instr.bit_sel) == g) ?
                status_register_q[sfo_pkg::SFO_BIT_T] : rd_val[g]; // see RULE1
        end
    endgenerate

    // debug data registered so the output comes from a flip-flop
    always_comb
    begin
        dbg_d = rd_val;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // flag lands at the edge, so the next instruction sees it, see RULE9
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            status_register_q <= sfo_pkg::SFO_STATUS_REGISTER_RST;
            done_q <= 1'b0;
            dbg_q <= sfo_pkg::SFO_REG_RST;
        end
        else if (clk_en)
        begin
            status_register_q <= status_register_d;
            done_q <= done_d;
            dbg_q <= dbg_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // every output is a flop or a bit of one
    assign status_register = status_register_q;
    assign irq_global_en = status_register_q[sfo_pkg::SFO_BIT_I];
    assign done = done_q;
    assign dbg_data = dbg_q;

endmodule : sfo_exec

`default_nettype wire

// *** rtl/sfo_pkg.sv ***
// package for the status flag set/clear execution block
package sfo_pkg;

    // ------------------------------------------------------------
    // status register bit positions
    // ------------------------------------------------------------
    localparam int unsigned SFO_BIT_C = 0;
    localparam int unsigned SFO_BIT_Z = 1;
    localparam int unsigned SFO_BIT_N = 2;
    localparam int unsigned SFO_BIT_V = 3;
    localparam int unsigned SFO_BIT_S = 4;
    localparam int unsigned SFO_BIT_H = 5;
    localparam int unsigned SFO_BIT_T = 6;
    localparam int unsigned SFO_BIT_I = 7;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int unsigned SFO_DATA_W = 8;
    localparam int unsigned SFO_REG_W = 5;
    localparam int unsigned SFO_NUM_REGS = 32;
    localparam int unsigned SFO_BSEL_W = 3;
    localparam logic [7:0] SFO_STATUS_REGISTER_RST = 8'h00;
    localparam logic [7:0] SFO_REG_RST = 8'h00;

    // ------------------------------------------------------------
    // operation codes, one-hot
    // ------------------------------------------------------------
    typedef enum logic [15:0] {
        SFO_OP_NONE       = 16'h0001,
        SFO_OP_BIT_LOAD   = 16'h0002,
        SFO_OP_BIT_STORE  = 16'h0004,
        SFO_OP_SET_C      = 16'h0008,
        SFO_OP_CLR_C      = 16'h0010,
        SFO_OP_SET_N      = 16'h0020,
        SFO_OP_CLR_N      = 16'h0040,
        SFO_OP_SET_Z      = 16'h0080,
        SFO_OP_CLR_Z      = 16'h0100,
        SFO_OP_IRQ_EN     = 16'h0200,
        SFO_OP_IRQ_DIS    = 16'h0400,
        SFO_OP_SET_S      = 16'h0800,
        SFO_OP_CLR_S      = 16'h1000,
        SFO_OP_SET_V      = 16'h2000,
        SFO_OP_CLR_V      = 16'h4000
    } sfo_op_t;

    // decoded instruction as handed over by the decoder
    typedef struct packed {
        logic valid;
        sfo_op_t op;
        logic [4:0] reg_sel;
        logic [2:0] bit_sel;
    } sfo_instr_t;

    // register file write request
    typedef struct packed {
        logic we;
        logic [4:0] addr;
        logic [7:0] data;
    } sfo_rf_wr_t;

endpackage : sfo_pkg

// *** rtl/sfo_regfile.sv ***
// working register file with one read port and one write port
`timescale 1ns/1ps
`default_nettype none

module sfo_regfile
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // read port
    input wire logic [4:0] rd_addr,
    output logic [7:0] rd_data,
    // write port
    input wire sfo_pkg::sfo_rf_wr_t wr
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] regs_q [sfo_pkg::SFO_NUM_REGS];
    logic [7:0] regs_d [sfo_pkg::SFO_NUM_REGS];

    // next value per entry, one write port
    always_comb
    begin
        for (int i = 0; i < sfo_pkg::SFO_NUM_REGS; i++)
        begin
            regs_d[i] = regs_q[i];
        end
        if (wr.we)
        begin
            regs_d[wr.addr] = wr.data;
        end
    end

    // registers frozen while clock enable is low
    generate
        for (genvar g = 0; g < sfo_pkg::SFO_NUM_REGS; g++)
        begin : g_entry
            always_ff @(posedge clk or posedge reset)
            begin
                if (reset)
                begin
                    regs_q[g] <= sfo_pkg::SFO_REG_RST;
                end
                else if (clk_en)
                begin
                    regs_q[g] <= regs_d[g];
                end
            end
        end
    endgenerate

    // read is combinational; bypass not needed as a write lands next edge
    assign rd_data = regs_q[rd_addr];

endmodule : sfo_regfile

`default_nettype wire

// *** testbench/sfo_exec_monitor.sv ***
// property checker for the flag set/clear execution block
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// checker on the top ports
// ------------------------------
module sfo_exec_monitor
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // watched inputs
    input wire logic clk_en,
    input wire sfo_pkg::sfo_instr_t instr,
    input wire logic status_register_load,
    // watched outputs
    input wire logic [7:0] dbg_data,
    input wire logic [7:0] status_register,
    input wire logic irq_global_en,
    input wire logic done
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // short names for the taken op and the flags
    logic go;
    logic [15:0] op;
    logic [7:0] sr;
    assign go = clk_en && instr.valid && $onehot(instr.op); // one-hot, so a bit names the op
    assign op = instr.op;
    assign sr = status_register;
    carry_flag_a: assert property (go && (op[3] || op[4]) |=> sr[0] == $past(op[3]))
        else $error("carry flag wrong");
    neg_flag_a: assert property (go && (op[5] || op[6]) |=> sr[2] == $past(op[5]))
        else $error("negative flag wrong");
    zero_flag_a: assert property (go && (op[7] || op[8]) |=> sr[1] == $past(op[7]))
        else $error("zero flag wrong");
    irq_flag_a: assert property (go && (op[9] || op[10])
        |=> sr[7] == $past(op[9]) && irq_global_en == sr[7])
        else $error("interrupt enable wrong");
    sign_flag_a: assert property (go && (op[11] || op[12]) |=> sr[4] == $past(op[11]))
        else $error("sign flag wrong");
    ovf_flag_a: assert property (go && (op[13] || op[14]) |=> sr[3] == $past(op[13]))
        else $error("overflow flag wrong");
    // a bit load must leave every flag alone unless a full load competes
    load_keeps_a: assert property (go && op[1] && !status_register_load |=> $stable(sr))
        else $error("bit load touched flags");
    store_bit_a: assert property (go && op[2] |=> sr[6] == dbg_data[$past(instr.bit_sel)])
        else $error("transfer flag wrong");
    done_pulse_a: assert property (go && !op[0] |=> done)
        else $error("done pulse missing");
    bad_code_a: assert property (clk_en && instr.valid && !$onehot(op) && !status_register_load
        |=> !done && $stable(sr))
        else $error("refused code changed state");
endmodule : sfo_exec_monitor
bind sfo_exec sfo_exec_monitor i_sfo_exec_monitor (.clk(clk), .reset(reset), .clk_en(clk_en),
    .instr(instr), .status_register_load(status_register_load), .dbg_data(dbg_data),
    .status_register(status_register), .irq_global_en(irq_global_en), .done(done));
`default_nettype wire

// *** testbench/status_flag_set_clear_ops_tb_top.sv ***
// self-checking bench for the flag set/clear execution block
`timescale 1ns/1ps
`default_nettype none
module status_flag_set_clear_ops_tb_top;
    // ------------------------------
    // stimulus and design
    // ------------------------------
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    sfo_pkg::sfo_instr_t instr = '0;
    logic status_register_load = 1'b0;
    logic [7:0] status_register_load_val = 8'hFF;
    sfo_pkg::sfo_rf_wr_t rf_ext_wr = '0;
    logic [4:0] dbg_addr = 5'h00;
    logic [7:0] dbg_data;
    logic [7:0] sr;
    logic irq_en;
    logic done;
    int mismatches = 0;
    int comparisons = 0;
    // rows: op code above, flags expected after it below
    logic [23:0] rows [12] = '{24'h000801, 24'h002005, 24'h008007, 24'h020087, 24'h080097,
        24'h20009F, 24'h00109E, 24'h00409A, 24'h010098, 24'h040018, 24'h100008, 24'h400000};
    // core clock, 40 ns
    always #20 clk = ~clk;
    sfo_exec i_sfo_exec (.clk(clk), .reset(reset), .clk_en(clk_en), .instr(instr),
        .status_register_load(status_register_load), .status_register_load_val(status_register_load_val), .rf_ext_wr(rf_ext_wr),
        .dbg_addr(dbg_addr), .dbg_data(dbg_data), .status_register(sr),
        .irq_global_en(irq_en), .done(done));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    // one op taken at the next edge, then looked at once it has landed
    task automatic issue(input logic [15:0] op, input logic [4:0] rs, input logic [2:0] bs);
        @(posedge clk);
        instr <= {1'b1, op, rs, bs};
        @(posedge clk);
        instr.valid <= 1'b0;
        #1;
    endtask : issue
    // dbg_data is registered, so wait two edges after the address
    task automatic peek(input logic [4:0] a);
        @(posedge clk);
        dbg_addr <= a;
        repeat (2) @(posedge clk);
        #1;
    endtask : peek
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    // main sequence
    initial
    begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk(sr, 8'h00);
        foreach (rows[i])
        begin
            issue(rows[i][23:8], 5'h00, 3'h0);
            chk(sr, rows[i][7:0]);
            chk({irq_en, done}, {rows[i][7], 1'b1});
        end
        $display("flag table done");
        // a bit travels through the transfer flag between registers
        @(posedge clk);
        rf_ext_wr <= '{1'b1, 5'h02, 8'hA5};
        @(posedge clk);
        rf_ext_wr.we <= 1'b0;
        issue(16'h0004, 5'h02, 3'h5);
        chk(sr, 8'h40);
        issue(16'h0002, 5'h03, 3'h6);
        chk(sr, 8'h40);
        issue(16'h0004, 5'h02, 3'h1);
        chk(sr, 8'h00);
        issue(16'h0002, 5'h02, 3'h0);
        peek(5'h03);
        chk(dbg_data, 8'h40);
        peek(5'h02);
        chk(dbg_data, 8'hA4);
        $display("bit move done");
        // unknown code, then a frozen enable: nothing may change
        issue(16'h0003, 5'h00, 3'h0);
        chk({done, sr[6:0]}, 8'h00);
        @(posedge clk);
        clk_en <= 1'b0;
        issue(16'h0008, 5'h00, 3'h0);
        chk(sr, 8'h00);
        @(posedge clk);
        clk_en <= 1'b1;
        status_register_load <= 1'b1;
        // own op wins over a full load on its bit only
        issue(16'h0010, 5'h00, 3'h0);
        chk(sr, 8'hFE);
        @(posedge clk);
        status_register_load <= 1'b0;
        // back to back: clear then set zero on adjacent edges
        instr <= {1'b1, 16'h0100, 8'h00};
        @(posedge clk);
        instr.op <= sfo_pkg::SFO_OP_SET_Z;
        #1;
        // the load still stood at the edge before, so carry came back
        chk(sr, 8'hFD);
        @(posedge clk);
        instr.valid <= 1'b0;
        #1;
        chk({sr[7:1], done}, 8'hFF);
        $display("awkward cases done");
        // reset in mid-run clears flags, pulse and the register file
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        #1;
        chk(sr, 8'h00);
        chk({irq_en, done, 6'h00}, 8'h00);
        peek(5'h02);
        chk(dbg_data, 8'h00);
        $display("mid-run reset done");
        complete_run();
    end
    // hang guard, far beyond the sixty or so cycles needed
    initial
    begin
        #100000;
        mismatches++;
        complete_run();
    end
endmodule : status_flag_set_clear_ops_tb_top
`default_nettype wire
